// ---- pkg/pad_mon_pkg.sv ----
// Constants, types and register map for the pad isolation and supply monitor controller.
// Assumes a plain single-cycle register port and one power controller clock.
package pad_mon_pkg;
  localparam logic [3:0] ADDR_PAD_ISO = 4'h0;
  localparam logic [3:0] ADDR_HS_LP = 4'h1;
  localparam logic [3:0] ADDR_MON_CFG = 4'h2;
  localparam logic [3:0] ADDR_MODE_CFG = 4'h3;
  localparam logic [3:0] ADDR_ISO_ACK = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_PAD_STAT = 4'h7;
  localparam logic [3:0] PAD_ISO_RESET = 4'hF;
  localparam logic [3:0] PAD_CLR_RESET = 4'hF;
  localparam logic [1:0] HS_LP_RESET = 2'h0;
  localparam logic [31:0] MON_CFG_RESET = 32'h00000000;
  localparam logic [3:0] MODE_CFG_RESET = 4'h0;
  localparam int MON_RSRV_BITS = 8;
  localparam int TRIP_BASE_MV = 650;
  localparam int TRIP_STEP_MV = 25;
  localparam int MODE_CFG_LC = 0;
  localparam int MODE_CFG_ISO = 1;
  localparam int MODE_CFG_HSLP = 2;
  localparam int MODE_CFG_DSOFF = 3;
  localparam int IRQ_PWR_GOOD = 0;
  localparam int IRQ_ENTRY = 1;
  localparam int IRQ_EXIT = 2;
  localparam int IRQ_VIOL = 3;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_DEEP_SLEEP, MODE_POWER_DOWN, MODE_DEEP_POWER_DOWN} pwr_mode_t;

  typedef struct packed {
    logic hvdEna;
    logic lvdEna;
    logic [3:0] lvdLvl;
    logic hvdRstEna;
    logic hvdIrqEna;
    logic lvdRstEna;
    logic lvdIrqEna;
  } dom_mon_t;

  typedef struct packed {
    // Top four bits of the word are unused; the struct must total 32 bits
    logic [3:0] rsrvHigh;
    dom_mon_t avd;
    dom_mon_t dom;
    logic [7:0] rsrvLow;
  } mon_cfg_t;

  typedef struct packed {
    logic overvolt;
    logic [3:0] tripCode;
    logic undervolt;
    logic overIrq;
    logic overRst;
    logic underIrq;
    logic underRst;
  } det_cfg_t;

  typedef struct packed {
    logic [3:0] latchClear;
    logic [3:0] isolate;
    logic [1:0] hsLowPower;
  } pad_ctl_t;
endpackage

// ---- src/pad_isolation_and_voltage_monitor_ctrl.sv ----
// Pad latch-clear, isolation and high-speed low-power sequencing plus supply monitor config.
// Assumes the mode sequencer gives one-cycle entry/exit pulses and level switch signals on this clock;
// detector and supply-good inputs are asynchronous and are synchronised here.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pad_isolation_and_voltage_monitor_ctrl
  import pad_mon_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // Mode sequencer
  input wire logic modeEntry,
  input wire logic modeExit,
  input wire pwr_mode_t modeKind,
  input wire logic [3:0] modeGroups,
  input wire logic switchOpenReq,
  input wire logic switchClosed,
  input wire logic cfgFromApp,
  input wire logic avdOwned,
  // Asynchronous supply indications
  input wire logic coreSupplyGood,
  input wire logic digitalSupplyOneOff,
  input wire logic [2:0] overvoltRaw,
  input wire logic [2:0] undervoltRaw,
  // Pads and detectors
  output pad_ctl_t padCtl,
  output logic switchOpenGrant,
  output det_cfg_t rtDetCfg,
  output det_cfg_t appDetCfg,
  output det_cfg_t avDetCfg,
  output logic monIrq,
  output logic monResetReq,
  output logic irq
);
  logic [7:0] syncA;
  logic [7:0] syncB;
  logic [3:0] isoSw_reg;
  logic [1:0] hsSw_reg;
  mon_cfg_t monCfg_reg;
  logic [3:0] modeCfg_reg;
  logic [3:0] irqStat_reg;
  logic [3:0] irqMask_reg;
  logic [3:0] lcSeq_reg;
  logic [3:0] isoSeq_reg;
  logic [3:0] isoHold_reg;
  logic [1:0] hsSeq_reg;
  logic porHold_reg;
  logic inMode_reg;
  pwr_mode_t mode_reg;
  logic [3:0] groups_reg;
  logic pendExit_reg;
  logic coreGood;
  logic dsOff;
  logic [2:0] ovSync;
  logic [2:0] uvSync;
  logic isoAck;
  logic [2:0] ovHit;
  logic [2:0] uvHit;
  logic [2:0] irqHit;
  logic [2:0] rstHit;
  logic deepPd;
  logic [3:0] ev;

  function automatic det_cfg_t toDet(input dom_mon_t d);
    toDet = '{overvolt: d.hvdEna, tripCode: d.lvdLvl, undervolt: d.lvdEna, overIrq: d.hvdIrqEna,
              overRst: d.hvdRstEna, underIrq: d.lvdIrqEna, underRst: d.lvdRstEna};
  endfunction

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
    end else begin
      syncA <= {digitalSupplyOneOff, coreSupplyGood, overvoltRaw[2:0], undervoltRaw[2:0]};
      syncB <= syncA;
    end
  end
  assign uvSync = syncB[2:0];
  assign ovSync = syncB[5:3];
  assign coreGood = syncB[6];
  assign dsOff = syncB[7];

  wire wrPadIso = regWrite && regAddr == ADDR_PAD_ISO;
  wire wrHsLp = regWrite && regAddr == ADDR_HS_LP;
  wire wrMon = regWrite && regAddr == ADDR_MON_CFG;
  wire wrMode = regWrite && regAddr == ADDR_MODE_CFG;
  wire wrStat = regWrite && regAddr == ADDR_IRQ_STAT;
  wire wrMask = regWrite && regAddr == ADDR_IRQ_MASK;
  assign isoAck = regWrite && regAddr == ADDR_ISO_ACK;
  assign deepPd = mode_reg == MODE_POWER_DOWN || mode_reg == MODE_DEEP_POWER_DOWN;

  // Software-owned configuration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      isoSw_reg <= 4'h0;
      hsSw_reg <= HS_LP_RESET;
      monCfg_reg <= MON_CFG_RESET;
      modeCfg_reg <= MODE_CFG_RESET;
      irqMask_reg <= 4'h0;
    end else begin
      if (wrPadIso) isoSw_reg <= regWdata[3:0];
      if (wrHsLp) hsSw_reg <= regWdata[1:0];
      if (wrMon) monCfg_reg <= {regWdata[31:MON_RSRV_BITS], 8'h00};
      if (wrMode) modeCfg_reg <= regWdata[3:0];
      if (wrMask) irqMask_reg <= regWdata[3:0];
    end
  end

  // Power-on hold released once the core supply is good
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      porHold_reg <= 1'b1;
    end else if (coreGood) begin
      porHold_reg <= 1'b0;
    end
  end

  // Mode tracking
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inMode_reg <= 1'b0;
      mode_reg <= MODE_SLEEP;
      groups_reg <= 4'h0;
      pendExit_reg <= 1'b0;
    end else begin
      if (modeEntry && !inMode_reg) begin
        inMode_reg <= 1'b1;
        mode_reg <= modeKind;
        groups_reg <= modeGroups;
      end else if (modeExit && inMode_reg) begin
        inMode_reg <= 1'b0;
        pendExit_reg <= deepPd;
      end
      if (pendExit_reg && switchClosed) pendExit_reg <= 1'b0;
    end
  end

  // Latch-clear sequencing around the domain switch
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lcSeq_reg <= 4'h0;
    end else if (modeEntry && !inMode_reg && modeCfg_reg[MODE_CFG_LC] &&
                 (modeKind == MODE_POWER_DOWN || modeKind == MODE_DEEP_POWER_DOWN)) begin
      lcSeq_reg <= lcSeq_reg | modeGroups;
    end else if (!inMode_reg && !pendExit_reg && switchClosed) begin
      lcSeq_reg <= 4'h0;
    end
  end

  // Isolation sequencing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      isoSeq_reg <= 4'h0;
      isoHold_reg <= 4'h0;
    end else begin
      if (modeEntry && !inMode_reg && modeKind != MODE_SLEEP && modeCfg_reg[MODE_CFG_ISO]) begin
        isoSeq_reg <= isoSeq_reg | modeGroups;
      end else if (modeExit && inMode_reg) begin
        if (deepPd) begin
          // Groups with latch-clear stay isolated until latch-clear ends; others wait for the acknowledge
          isoHold_reg <= isoHold_reg | (isoSeq_reg & ~lcSeq_reg);
          isoSeq_reg <= 4'h0;
        end else begin
          isoSeq_reg <= 4'h0;
        end
      end
      if (isoAck) isoHold_reg <= 4'h0;
    end
  end

  // High-speed pad low-power sequencing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hsSeq_reg <= 2'h0;
    end else if (modeEntry && !inMode_reg) begin
      hsSeq_reg <= (modeKind != MODE_SLEEP && modeCfg_reg[MODE_CFG_HSLP]) ? 2'h3 : 2'h0;
    end else if (modeExit && inMode_reg) begin
      hsSeq_reg <= 2'h0;
    end
  end

  // Registered pad outputs; application groups may be held off until supply-off seen
  wire [3:0] isoAll = isoSw_reg | isoSeq_reg | isoHold_reg | {4{porHold_reg}};
  wire [3:0] isoGate = (modeCfg_reg[MODE_CFG_DSOFF] && inMode_reg && deepPd && !dsOff) ?
                       {2'b00, 2'b11} : 4'hF;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      padCtl <= '{latchClear: PAD_CLR_RESET, isolate: PAD_ISO_RESET, hsLowPower: HS_LP_RESET};
      switchOpenGrant <= 1'b0;
    end else begin
      padCtl.latchClear <= lcSeq_reg | {4{porHold_reg}};
      padCtl.isolate <= (isoAll & (isoGate | isoSw_reg | {4{porHold_reg}})) | lcSeq_reg;
      padCtl.hsLowPower <= hsSw_reg | hsSeq_reg;
      // Switch may open only once latch-clear is at the pads
      switchOpenGrant <= switchOpenReq && ((padCtl.latchClear & groups_reg) == (lcSeq_reg & groups_reg));
    end
  end

  // Detector configuration routing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rtDetCfg <= '0;
      appDetCfg <= '0;
      avDetCfg <= '0;
    end else begin
      if (!cfgFromApp) rtDetCfg <= toDet(monCfg_reg.dom);
      if (cfgFromApp) appDetCfg <= toDet(monCfg_reg.dom);
      if (avdOwned) avDetCfg <= toDet(monCfg_reg.avd);
    end
  end

  // Violations gated by each detector's own enables
  always_comb begin
    ovHit = ovSync & {avDetCfg.overvolt, appDetCfg.overvolt, rtDetCfg.overvolt};
    uvHit = uvSync & {avDetCfg.undervolt, appDetCfg.undervolt, rtDetCfg.undervolt};
    irqHit = (ovHit & {avDetCfg.overIrq, appDetCfg.overIrq, rtDetCfg.overIrq}) |
             (uvHit & {avDetCfg.underIrq, appDetCfg.underIrq, rtDetCfg.underIrq});
    rstHit = (ovHit & {avDetCfg.overRst, appDetCfg.overRst, rtDetCfg.overRst}) |
             (uvHit & {avDetCfg.underRst, appDetCfg.underRst, rtDetCfg.underRst});
    ev = 4'h0;
    ev[IRQ_PWR_GOOD] = porHold_reg && coreGood;
    ev[IRQ_ENTRY] = modeEntry && !inMode_reg;
    ev[IRQ_EXIT] = modeExit && inMode_reg;
    ev[IRQ_VIOL] = |irqHit;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irqStat_reg <= 4'h0;
      monIrq <= 1'b0;
      monResetReq <= 1'b0;
      irq <= 1'b0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~(wrStat ? regWdata[3:0] : 4'h0)) | ev;
      monIrq <= |irqHit;
      monResetReq <= |rstHit;
      irq <= |(((irqStat_reg & ~(wrStat ? regWdata[3:0] : 4'h0)) | ev) & irqMask_reg);
    end
  end

  // Read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_PAD_ISO: regRdata <= {28'h0000000, isoSw_reg};
        ADDR_HS_LP: regRdata <= {30'h00000000, hsSw_reg};
        ADDR_MON_CFG: regRdata <= monCfg_reg;
        ADDR_MODE_CFG: regRdata <= {28'h0000000, modeCfg_reg};
        ADDR_IRQ_STAT: regRdata <= {28'h0000000, irqStat_reg};
        ADDR_IRQ_MASK: regRdata <= {28'h0000000, irqMask_reg};
        ADDR_PAD_STAT: regRdata <= {22'h000000, padCtl};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end
endmodule

// ---- tb/pad_mon_monitor.sv ----
// Port checker for the pad isolation and supply monitor controller.
// Sees only top-level ports; bound from the testbench top.
`timescale 1ns/1ps
module pad_mon_monitor
  import pad_mon_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  // Sequencer and supplies
  input wire logic switchClosed,
  input wire logic cfgFromApp,
  input wire logic avdOwned,
  input wire logic coreSupplyGood,
  input wire logic [2:0] overvoltRaw,
  input wire logic [2:0] undervoltRaw,
  // Pads and detectors
  input wire pad_ctl_t padCtl,
  input wire det_cfg_t rtDetCfg,
  input wire det_cfg_t avDetCfg,
  input wire logic monIrq,
  input wire logic monResetReq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rsvd; regRead && regAddr == ADDR_MON_CFG |=> regRdata[7:0] == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved monitor bits read nonzero");
  property p_por; (!coreSupplyGood)[*4] |-> padCtl.latchClear == 4'hF && padCtl.isolate == 4'hF; endproperty
  a_por: assert property (p_por) else $error("pads released before supply good");
  property p_rst; $rose(rst_n) |-> padCtl.hsLowPower == 2'h0 && !monIrq && !monResetReq; endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_trip;
    (regWrite && regAddr == ADDR_MON_CFG && !cfgFromApp) ##1 (!regWrite && !cfgFromApp)[*2]
    |=> rtDetCfg.tripCode == $past(regWdata[15:12], 3) && rtDetCfg.overvolt == $past(regWdata[17], 3);
  endproperty
  a_trip: assert property (p_trip) else $error("real-time trip config not applied");
  // Ownership may be registered inside, so allow three settling cycles
  property p_av; (!avdOwned)[*4] |-> $stable(avDetCfg); endproperty
  a_av: assert property (p_av) else $error("av config changed without ownership");
  property p_irq; (overvoltRaw[0] && rtDetCfg.overvolt && rtDetCfg.overIrq)[*4] |=> monIrq; endproperty
  a_irq: assert property (p_irq) else $error("overvoltage interrupt missing");
  property p_rreq; (undervoltRaw[0] && rtDetCfg.undervolt && rtDetCfg.underRst)[*4] |=> monResetReq; endproperty
  a_rreq: assert property (p_rreq) else $error("undervoltage reset request missing");
  property p_lc; $fell(padCtl.latchClear[0]) |-> $past(switchClosed); endproperty
  a_lc: assert property (p_lc) else $error("latch clear released with switch open");
endmodule

// ---- tb/pad_mon_partner.sv ----
// Behavioural supply detectors beside the controller.
// Supply ramp and trips are commanded by the testbench after clock edges.
`timescale 1ns/1ps
module pad_mon_partner
  import pad_mon_pkg::*;
(
  // Clock and commands
  input wire logic clock,
  input wire logic supplyUp,
  input wire logic [2:0] overTrip,
  input wire logic [2:0] underTrip,
  // Detector configuration
  input wire det_cfg_t rtDetCfg,
  input wire det_cfg_t appDetCfg,
  input wire det_cfg_t avDetCfg,
  // Detector outputs
  output logic coreSupplyGood,
  output logic [2:0] overvoltRaw,
  output logic [2:0] undervoltRaw
);
  logic [2:0] ramp = 3'h0;
  // Supply needs a few cycles to rise, so good is never instant
  always_ff @(posedge clock) ramp <= supplyUp ? ((ramp == 3'h7) ? ramp : ramp + 3'h1) : 3'h0;
  assign coreSupplyGood = ramp == 3'h7;
  // A disabled detector reports nothing
  assign overvoltRaw = overTrip & {avDetCfg.overvolt, appDetCfg.overvolt, rtDetCfg.overvolt};
  assign undervoltRaw = underTrip & {avDetCfg.undervolt, appDetCfg.undervolt, rtDetCfg.undervolt};
endmodule

// ---- tb/pad_isolation_and_voltage_monitor_ctrl_tb.sv ----
// Self-checking bench for the pad isolation and supply monitor controller.
// Drives register port and mode sequencer; detectors come from the partner model.
`timescale 1ns/1ps
module pad_isolation_and_voltage_monitor_ctrl_tb;
  import pad_mon_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] regAddr = 4'h0;
  logic [3:0] modeGroups = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata, v;
  logic regWrite = 1'h0, regRead = 1'h0, modeEntry = 1'h0, modeExit = 1'h0, switchOpenReq = 1'h0;
  logic switchClosed = 1'h1, cfgFromApp = 1'h0, avdOwned = 1'h1, supplyUp = 1'h0, dsOffIn = 1'h0;
  logic coreSupplyGood, switchOpenGrant, monIrq, monResetReq, irq;
  logic [2:0] overTrip = 3'h0, underTrip = 3'h0, overvoltRaw, undervoltRaw;
  logic [31:0] words [3] = '{32'h0DEB3AFF, 32'h0BCFF500, 32'h00000000};
  pwr_mode_t modeKind = MODE_SLEEP;
  pad_ctl_t padCtl;
  det_cfg_t rtDetCfg, appDetCfg, avDetCfg;
  int error_cnt = 0, samples_checked = 0;
  pad_isolation_and_voltage_monitor_ctrl i_pad_isolation_and_voltage_monitor_ctrl(.clock, .rst_n, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .modeEntry, .modeExit, .modeKind, .modeGroups, .switchOpenReq,
    .switchClosed, .cfgFromApp, .avdOwned, .coreSupplyGood, .digitalSupplyOneOff(dsOffIn), .overvoltRaw,
    .undervoltRaw, .padCtl, .switchOpenGrant, .rtDetCfg, .appDetCfg, .avDetCfg, .monIrq, .monResetReq, .irq);
  pad_mon_partner i_pad_mon_partner(.clock, .supplyUp, .overTrip, .underTrip, .rtDetCfg, .appDetCfg,
    .avDetCfg, .coreSupplyGood, .overvoltRaw, .undervoltRaw);
  initial forever #2.5 clock = ~clock;
  // Monitor domain field to detector config order
  function automatic logic [31:0] dcfg(input logic [9:0] d);
    return {22'h0, d[9], d[7:4], d[8], d[2], d[3], d[0], d[1]};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clock);
    regRead <= 1'h0;
    #1 d = regRdata;
  endtask
  task automatic mode(input logic ent, input pwr_mode_t k, input logic [3:0] g);
    @(posedge clock);
    modeKind <= k;
    modeGroups <= g;
    modeEntry <= ent;
    modeExit <= !ent;
    @(posedge clock);
    modeEntry <= 1'h0;
    modeExit <= 1'h0;
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    cy(8);
    chk("padReset", 32'h3FC, 32'(padCtl));
    supplyUp <= 1'h1;
    cy(20);
    chk("latchClearPor", 32'h0, 32'(padCtl.latchClear));
    rd(ADDR_IRQ_STAT, v);
    chk("status", 32'h1, v);
    wr(ADDR_IRQ_MASK, 32'hF);
    cy(2);
    chk("irqOpen", 32'h1, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h0);
    cy(2);
    chk("irqMasked", 32'h0, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'hF);
    wr(ADDR_IRQ_STAT, 32'h1);
    cy(2);
    chk("irqCleared", 32'h0, 32'(irq));
    rd(4'hF, v);
    chk("unmapped", 32'h0, v);
    wr(ADDR_PAD_ISO, 32'h5);
    wr(ADDR_HS_LP, 32'h2);
    cy(2);
    chk("padSw", 32'h16, 32'({padCtl.isolate, padCtl.hsLowPower}));
    wr(ADDR_PAD_ISO, 32'h0);
    wr(ADDR_HS_LP, 32'h0);
    foreach (words[i]) begin
      cfgFromApp <= i[0];
      wr(ADDR_MON_CFG, words[i]);
      cy(3);
      rd(ADDR_MON_CFG, v);
      chk("monWord", words[i] & 32'hFFFFFF00, v);
      chk("domCfg", dcfg(words[i][17:8]), 32'(i[0] ? appDetCfg : rtDetCfg));
      chk("avCfg", dcfg(words[i][27:18]), 32'(avDetCfg));
    end
    avdOwned <= 1'h0;
    wr(ADDR_MON_CFG, 32'h0FF30600);
    cy(3);
    chk("avHeld", 32'h0, 32'(avDetCfg));
    overTrip <= 3'h1;
    cy(6);
    chk("irqReq", 32'h1, 32'({monResetReq, monIrq}));
    overTrip <= 3'h0;
    underTrip <= 3'h1;
    cy(6);
    chk("rstReq", 32'h1, 32'(monResetReq));
    underTrip <= 3'h0;
    avdOwned <= 1'h1;
    wr(ADDR_MODE_CFG, 32'h3);
    mode(1'h1, MODE_POWER_DOWN, 4'h5);
    cy(3);
    chk("pdEntry", 32'h55, 32'({padCtl.latchClear, padCtl.isolate}));
    switchClosed <= 1'h0;
    switchOpenReq <= 1'h1;
    cy(3);
    chk("grant", 32'h1, 32'(switchOpenGrant));
    mode(1'h0, MODE_POWER_DOWN, 4'h5);
    cy(3);
    chk("lcHeld", 32'h5, 32'(padCtl.latchClear));
    switchOpenReq <= 1'h0;
    switchClosed <= 1'h1;
    cy(4);
    chk("pdDone", 32'h0, 32'({padCtl.latchClear, padCtl.isolate}));
    wr(ADDR_MODE_CFG, 32'h2);
    mode(1'h1, MODE_POWER_DOWN, 4'hF);
    mode(1'h0, MODE_POWER_DOWN, 4'hF);
    cy(4);
    chk("isoWait", 32'hF, 32'(padCtl.isolate));
    wr(ADDR_ISO_ACK, 32'h1);
    cy(3);
    chk("isoAck", 32'h0, 32'(padCtl.isolate));
    mode(1'h1, MODE_DEEP_SLEEP, 4'hF);
    cy(3);
    chk("dsIso", 32'hF, 32'(padCtl.isolate));
    mode(1'h0, MODE_DEEP_SLEEP, 4'hF);
    cy(3);
    chk("dsIsoOff", 32'h0, 32'(padCtl.isolate));
    wr(ADDR_MODE_CFG, 32'hA);
    mode(1'h1, MODE_POWER_DOWN, 4'hF);
    cy(3);
    chk("dsOffWait", 32'h3, 32'(padCtl.isolate));
    dsOffIn <= 1'h1;
    cy(4);
    chk("dsOffSeen", 32'hF, 32'(padCtl.isolate));
    mode(1'h0, MODE_POWER_DOWN, 4'hF);
    wr(ADDR_ISO_ACK, 32'h1);
    wr(ADDR_MODE_CFG, 32'h4);
    for (int k = 0; k < 4; k++) begin
      mode(1'h1, pwr_mode_t'(k), 4'hF);
      cy(3);
      chk("hsEntry", (k == 0) ? 32'h0 : 32'h3, 32'(padCtl.hsLowPower));
      mode(1'h0, pwr_mode_t'(k), 4'hF);
      cy(3);
      chk("hsExit", 32'h0, 32'(padCtl.hsLowPower));
    end
    report_and_stop();
  end
endmodule
bind pad_isolation_and_voltage_monitor_ctrl pad_mon_monitor i_pad_mon_monitor(.clock, .rst_n, .regAddr,
  .regWdata, .regWrite, .regRead, .regRdata, .switchClosed, .cfgFromApp, .avdOwned, .coreSupplyGood,
  .overvoltRaw, .undervoltRaw, .padCtl, .rtDetCfg, .avDetCfg, .monIrq, .monResetReq);
